// >>> sdcs_pkg.sv
// Package for the switched digital call supervisor
// Assumes a 25 MHz reference clock and a one-millisecond timebase derived in the core
package sdcs_pkg;
   // =====================================================
   // Clock and timing
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned MS_PER_S = 1000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
   localparam int unsigned NO_WINK_S = 10;
   localparam int unsigned NO_WINK_MS = NO_WINK_S * MS_PER_S;
   localparam int unsigned WINK_HIT_MS = 70;
   localparam int unsigned WINK_GLARE_MS = 350;
   localparam int unsigned ANSWER_HIT_MS = 600;
   localparam int unsigned ANSWER_VALID_S = 2;
   localparam int unsigned ANSWER_VALID_MS = ANSWER_VALID_S * MS_PER_S;
   localparam int unsigned SEIZE_HIT_MS = 35;
   localparam int unsigned SEIZE_VALID_MS = 90;
   localparam int unsigned PULSE_MS = 60;
   localparam int unsigned INTERDIGIT_MS = 600;
   localparam int unsigned DISC_MS = 2000;
   localparam int unsigned RATE_KBPS = 56;
   // =====================================================
   // Widths and reset values
   localparam int unsigned MS_W = 16;
   localparam int unsigned DIGIT_W = 4;
   localparam int unsigned NUM_DIGITS = 16;
   localparam int unsigned IDX_W = 4;
   localparam logic [7:0] RATE_RST = 8'h00;
   localparam logic [DIGIT_W-1:0] ZERO_DIGIT_PULSES = 4'hA;
   // =====================================================
   // Supervisor states
   typedef enum logic [3:0] {
      SDCS_IDLE, SDCS_SEIZE, SDCS_WINK, SDCS_NOWINK, SDCS_DIAL_MARK, SDCS_DIAL_SPACE,
      SDCS_INTERDIGIT, SDCS_ANSWER_WAIT, SDCS_ANSWER, SDCS_CONNECTED, SDCS_HANGUP_ASK,
      SDCS_IN_SEIZE
   } sdcs_state_e;
   // Event pulses toward the user
   typedef struct packed {
      logic no_wink;
      logic hit;
      logic glare;
      logic seize_hit;
      logic remote_disc;
      logic local_disc;
      logic remote_seize;
   } sdcs_event_s;
   // Operator commands
   typedef struct packed {
      logic dial;
      logic cont;
      logic quit;
      logic hangup;
      logic confirm;
      logic ctrl_code;
   } sdcs_cmd_s;
endpackage

// >>> sdcs_core.sv
// Call supervision for a four-wire switched digital loop, as caller or receiver
// Assumes the loop receiver gives data-mode and signal-present levels from another domain
// Operation
// R1: Switched digital mode fixes loop rate at 56 kbit/s only.
// R2: Flag loss of signal whenever no receive signal is present.
// R3: Caller places loop in data mode as seizure request.
// R4: Network returns data mode as wink when ready for pulses.
// R5: Dial only after wink detected; show dialing status meanwhile.
// R6: No wink within 10 s raises beep and no-wink event.
// R7: After no-wink, continue sends digits anyway; exit abandons the call.
// R8: Each digit is pulses alternating data mode and idle.
// R9: Idle and all-ones indicators toggle with dial pulses.
// R10: After last digit, watch receive path for answer.
// R11: Network passes answer as data mode over two seconds.
// R12: Valid answer enters established state, reports connected.
// R13: Hit when wink under 70 ms or answer under 600 ms.
// R14: Glare when wink lasts longer than 350 ms.
// R15: Sending control codes during call signals hang-up, ends call.
// R16: Detect far-end clear and report remote disconnect.
// R17: After a call ends, send idle and wait for calls.
// R18: Idle in switched mode, watch receive for incoming data-mode seizure.
// R19: Incoming data mode over 90 ms is valid seizure, establishes call.
// R20: Data mode under 35 ms before valid seizure reports seizure hit.
// R21: Millisecond tick timing; 35 to 90 ms intervals ignored silently.
// R22: Local hang-up needs confirm, then idle and local disconnect.
`timescale 1ns/1ps
`default_nettype none
module sdcs_core #(
   parameter int unsigned CLK_HZ_P = sdcs_pkg::CLK_HZ,
   parameter int unsigned NO_WINK_MS_P = sdcs_pkg::NO_WINK_MS,
   parameter int unsigned ND = sdcs_pkg::NUM_DIGITS
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RESET_N,
   // Mode and loop receive
   input wire logic SW_MODE,
   input wire logic RX_DATA_MODE,
   input wire logic RX_SIGNAL,
   // Operator commands and number
   input wire sdcs_pkg::sdcs_cmd_s CMD,
   input wire logic [sdcs_pkg::DIGIT_W-1:0] DIGITS [ND],
   input wire logic [sdcs_pkg::IDX_W-1:0] DIGIT_COUNT,
   // Loop transmit and status
   output logic TX_DATA_MODE,
   output logic LED_IDLE,
   output logic LED_ALL_ONES,
   output logic [7:0] RATE_KBPS_O,
   output logic LOS,
   output logic DIALING,
   output logic WAIT_WINK,
   output logic WAIT_ANSWER,
   output logic CONNECTED,
   output logic BEEP,
   output sdcs_pkg::sdcs_event_s EVT
);
   import sdcs_pkg::*;

   localparam int unsigned CPM = CLK_HZ_P / MS_PER_S;
   localparam logic [MS_W-1:0] NOWINK_LIM = MS_W'(NO_WINK_MS_P);

   // =====================================================
   // Input synchronisers
   logic [1:0] dm_sync_ff, sig_sync_ff;
   logic rx_dm, rx_dm_d_ff;
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         dm_sync_ff <= 2'h0;
         sig_sync_ff <= 2'h0;
         rx_dm_d_ff <= 1'b0;
      end else begin
         dm_sync_ff <= {dm_sync_ff[0], RX_DATA_MODE};
         sig_sync_ff <= {sig_sync_ff[0], RX_SIGNAL};
         rx_dm_d_ff <= dm_sync_ff[1];
      end
   end
   assign rx_dm = dm_sync_ff[1];

   // =====================================================
   // Millisecond tick
   logic [15:0] pre_ff;
   logic tick;
   assign tick = (pre_ff == 16'(CPM - 1));
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pre_ff <= 16'h0000;
      end else begin
         pre_ff <= tick ? 16'h0000 : pre_ff + 16'h0001; // [R21]
      end
   end

   // =====================================================
   // Line status
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         LOS <= 1'b1;
         RATE_KBPS_O <= RATE_RST;
      end else begin
         LOS <= ~sig_sync_ff[1]; // [R2]
         RATE_KBPS_O <= SW_MODE ? 8'(RATE_KBPS) : RATE_RST; // [R1]
      end
   end

   // =====================================================
   // State machine with timers
   sdcs_state_e st_ff, nxt_st;
   logic [MS_W-1:0] ms_ff, nxt_ms;    // time in state
   logic [MS_W-1:0] dur_ff, nxt_dur;  // receive data-mode length
   logic [IDX_W-1:0] idx_ff, nxt_idx;
   logic [DIGIT_W-1:0] pls_ff, nxt_pls;
   logic seized_ff, nxt_seized;
   sdcs_event_s nxt_evt;
   logic rise, fall;
   assign rise = rx_dm & ~rx_dm_d_ff;
   assign fall = ~rx_dm & rx_dm_d_ff;

   // Pulse count for one digit, zero dials ten
   function automatic logic [DIGIT_W-1:0] pulses_of(input logic [DIGIT_W-1:0] d);
      pulses_of = (d == 4'h0) ? ZERO_DIGIT_PULSES : d;
   endfunction

   always_comb begin
      nxt_st = st_ff;
      nxt_ms = (tick && ms_ff != {MS_W{1'b1}}) ? ms_ff + 1'b1 : ms_ff;
      nxt_dur = rx_dm ? ((tick && dur_ff != {MS_W{1'b1}}) ? dur_ff + 1'b1 : dur_ff)
                      : '0;
      nxt_idx = idx_ff;
      nxt_pls = pls_ff;
      nxt_seized = seized_ff;
      nxt_evt = '0;
      if (!SW_MODE) begin
         nxt_st = SDCS_IDLE;
         nxt_seized = 1'b0;
      end else begin
         unique case (st_ff)
            SDCS_IDLE: begin
               if (CMD.dial) begin
                  nxt_st = SDCS_SEIZE; // [R3]
                  nxt_ms = '0;
               end else if (rise) begin
                  nxt_st = SDCS_IN_SEIZE; // [R18]
               end
            end
            SDCS_IN_SEIZE: begin
               if (dur_ff > MS_W'(SEIZE_VALID_MS)) begin
                  nxt_st = SDCS_CONNECTED; // [R19]
                  nxt_seized = 1'b1;
                  nxt_evt.remote_seize = 1'b1;
               end else if (fall) begin
                  nxt_st = SDCS_IDLE;
                  nxt_evt.seize_hit = (dur_ff < MS_W'(SEIZE_HIT_MS)) & ~seized_ff; // [R20] [R21]
               end
            end
            SDCS_SEIZE: begin
               if (rise) begin
                  nxt_st = SDCS_WINK; // [R4]
               end else if (ms_ff >= NOWINK_LIM) begin
                  nxt_st = SDCS_NOWINK; // [R6]
                  nxt_evt.no_wink = 1'b1;
               end
            end
            SDCS_WINK: begin
               if (dur_ff > MS_W'(WINK_GLARE_MS)) begin
                  nxt_st = SDCS_IDLE; // [R14]
                  nxt_evt.glare = 1'b1;
               end else if (fall) begin
                  if (dur_ff < MS_W'(WINK_HIT_MS)) begin
                     nxt_st = SDCS_SEIZE; // [R13]
                     nxt_evt.hit = 1'b1;
                  end else begin
                     nxt_st = SDCS_INTERDIGIT; // [R5]
                     nxt_idx = '0;
                     nxt_ms = '0;
                  end
               end
            end
            SDCS_NOWINK: begin
               if (CMD.cont) begin
                  nxt_st = SDCS_INTERDIGIT; // [R7]
                  nxt_idx = '0;
                  nxt_ms = '0;
               end else if (CMD.quit) begin
                  nxt_st = SDCS_IDLE; // [R7]
               end
            end
            SDCS_INTERDIGIT: begin
               if (idx_ff >= DIGIT_COUNT) begin
                  nxt_st = SDCS_ANSWER_WAIT; // [R10]
               end else if (ms_ff >= MS_W'(INTERDIGIT_MS)) begin
                  nxt_st = SDCS_DIAL_MARK;
                  nxt_pls = pulses_of(DIGITS[idx_ff]);
                  nxt_ms = '0;
               end
            end
            SDCS_DIAL_MARK: begin
               if (ms_ff >= MS_W'(PULSE_MS)) begin
                  nxt_st = SDCS_DIAL_SPACE; // [R8]
                  nxt_ms = '0;
                  nxt_pls = pls_ff - 1'b1;
               end
            end
            SDCS_DIAL_SPACE: begin
               if (ms_ff >= MS_W'(PULSE_MS)) begin
                  nxt_ms = '0;
                  if (pls_ff == '0) begin
                     nxt_st = SDCS_INTERDIGIT; // [R8]
                     nxt_idx = idx_ff + 1'b1;
                  end else begin
                     nxt_st = SDCS_DIAL_MARK;
                  end
               end
            end
            SDCS_ANSWER_WAIT: begin
               if (rise) begin
                  nxt_st = SDCS_ANSWER; // [R10]
               end
            end
            SDCS_ANSWER: begin
               if (dur_ff > MS_W'(ANSWER_VALID_MS)) begin
                  nxt_st = SDCS_CONNECTED; // [R11] [R12]
               end else if (fall) begin
                  nxt_st = SDCS_ANSWER_WAIT;
                  nxt_evt.hit = (dur_ff < MS_W'(ANSWER_HIT_MS)); // [R13]
               end
            end
            SDCS_CONNECTED: begin
               if (CMD.ctrl_code) begin
                  nxt_st = SDCS_IDLE; // [R15] [R17]
                  nxt_evt.local_disc = 1'b1;
                  nxt_seized = 1'b0;
               end else if (!rx_dm) begin
                  nxt_st = SDCS_IDLE; // [R16] [R17]
                  nxt_evt.remote_disc = 1'b1;
                  nxt_seized = 1'b0;
               end else if (CMD.hangup) begin
                  nxt_st = SDCS_HANGUP_ASK; // [R22]
               end
            end
            SDCS_HANGUP_ASK: begin
               if (CMD.confirm) begin
                  nxt_st = SDCS_IDLE; // [R22]
                  nxt_evt.local_disc = 1'b1;
                  nxt_seized = 1'b0;
               end else if (CMD.quit) begin
                  nxt_st = SDCS_CONNECTED;
               end else if (!rx_dm) begin
                  nxt_st = SDCS_IDLE; // [R16]
                  nxt_evt.remote_disc = 1'b1;
                  nxt_seized = 1'b0;
               end
            end
            default: nxt_st = SDCS_IDLE;
         endcase
      end
   end

   // State register and seizure memory
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         st_ff <= SDCS_IDLE;
         seized_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         seized_ff <= nxt_seized;
      end
   end

   // Time in state and receive data-mode length [R21]
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ms_ff <= '0;
         dur_ff <= '0;
      end else begin
         ms_ff <= nxt_ms;
         dur_ff <= nxt_dur;
      end
   end

   // Digit position and pulses left in the current digit
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         idx_ff <= '0;
         pls_ff <= '0;
      end else begin
         idx_ff <= nxt_idx;
         pls_ff <= nxt_pls;
      end
   end

   // One-cycle event pulses
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         EVT <= '0;
      end else begin
         EVT <= nxt_evt;
      end
   end

   // =====================================================
   // Loop transmit and status outputs
   logic nxt_tx;
   always_comb begin
      unique case (nxt_st)
         SDCS_SEIZE, SDCS_WINK, SDCS_NOWINK, SDCS_DIAL_MARK, SDCS_INTERDIGIT,
         SDCS_ANSWER_WAIT, SDCS_ANSWER, SDCS_CONNECTED, SDCS_HANGUP_ASK: nxt_tx = 1'b1;
         default: nxt_tx = 1'b0; // Idle code otherwise [R17]
      endcase
   end

   // Loop level and its two indicators
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         TX_DATA_MODE <= 1'b0;
         LED_IDLE <= 1'b1;
         LED_ALL_ONES <= 1'b0;
      end else begin
         TX_DATA_MODE <= nxt_tx; // [R3] [R8]
         LED_IDLE <= ~nxt_tx; // [R9]
         LED_ALL_ONES <= nxt_tx; // [R9]
      end
   end

   // Call progress levels
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         DIALING <= 1'b0;
         WAIT_WINK <= 1'b0;
         WAIT_ANSWER <= 1'b0;
         CONNECTED <= 1'b0;
      end else begin
         DIALING <= (nxt_st == SDCS_DIAL_MARK) || (nxt_st == SDCS_DIAL_SPACE)
                    || (nxt_st == SDCS_INTERDIGIT); // [R5]
         WAIT_WINK <= (nxt_st == SDCS_SEIZE) || (nxt_st == SDCS_WINK);
         WAIT_ANSWER <= (nxt_st == SDCS_ANSWER_WAIT) || (nxt_st == SDCS_ANSWER);
         CONNECTED <= (nxt_st == SDCS_CONNECTED) || (nxt_st == SDCS_HANGUP_ASK); // [R12]
      end
   end

   // Audible alert while the no-wink choice is pending
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         BEEP <= 1'b0;
      end else begin
         BEEP <= (nxt_st == SDCS_NOWINK); // [R6]
      end
   end
endmodule
`default_nettype wire

// >>> sdcs_sva.sv
// Port checker for the switched digital call supervisor
// Assumes it is bound onto sdcs_core with the same clock rate parameter
`timescale 1ns/1ps
`default_nettype none
module sdcs_sva #(
   parameter int unsigned CLK_HZ_P = 25000000
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RESET_N,
   // Loop side
   input wire logic SW_MODE,
   input wire logic RX_DATA_MODE,
   input wire logic RX_SIGNAL,
   input wire logic TX_DATA_MODE,
   // Status and events
   input wire logic LED_IDLE,
   input wire logic LED_ALL_ONES,
   input wire logic [7:0] RATE_KBPS_O,
   input wire logic LOS,
   input wire logic DIALING,
   input wire logic WAIT_WINK,
   input wire logic WAIT_ANSWER,
   input wire logic CONNECTED,
   input wire logic BEEP,
   input wire sdcs_pkg::sdcs_event_s EVT
);
   import sdcs_pkg::*;
   localparam int unsigned CPM = CLK_HZ_P / 1000;
   logic [31:0] run_ff;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);
   // Length of the current receive data-mode run
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         run_ff <= '0;
      end else begin
         run_ff <= RX_DATA_MODE ? run_ff + 32'h1 : 32'h0;
      end
   end
   rate_fix_a: assert property (SW_MODE |=> RATE_KBPS_O == 8'h38)
      else $error("rate not fixed at 56");
   los_on_a: assert property (!RX_SIGNAL [*5] |-> LOS)
      else $error("loss of signal not flagged");
   los_off_a: assert property (RX_SIGNAL [*5] |-> !LOS)
      else $error("loss of signal stuck");
   led_pair_a: assert property (LED_IDLE == !TX_DATA_MODE && LED_ALL_ONES == TX_DATA_MODE)
      else $error("indicators not in step with loop");
   seize_tx_a: assert property (WAIT_WINK |-> TX_DATA_MODE)
      else $error("no seizure while waiting for wink");
   nowink_beep_a: assert property (EVT.no_wink |-> ##[0:1] BEEP)
      else $error("no-wink without beep");
   connect_len_a: assert property ($rose(CONNECTED) |-> run_ff > 89 * CPM)
      else $error("call set up on short data mode");
   remote_disc_a: assert property (EVT.remote_disc |-> ##[0:1] (!CONNECTED && !TX_DATA_MODE))
      else $error("remote clear left call up");
   local_disc_a: assert property (EVT.local_disc |-> ##[0:1] (!CONNECTED && !TX_DATA_MODE))
      else $error("local clear left call up");
   dial_excl_a: assert property (DIALING |-> !WAIT_ANSWER && !CONNECTED)
      else $error("dialing overlaps answer wait");
endmodule
`default_nettype wire

// >>> sdcs_net_model.sv
// Network switch model on the four-wire loop
// Assumes the bench calls its tasks; levels change on falling edges
`timescale 1ns/1ps
`default_nettype none
module sdcs_net_model #(
   parameter int CPM = 3
) (
   // Clock and loop transmit
   input wire logic ref_clk,
   input wire logic tx_data_mode,
   // Loop receive toward the block
   output logic rx_data_mode,
   output logic rx_signal
);
   // Loop idle, no signal at start
   initial begin
      rx_data_mode = 1'b0;
      rx_signal = 1'b0;
   end
   // Data mode for ms milliseconds, then a short idle gap
   task automatic burst(input int ms);
      @(negedge ref_clk);
      rx_data_mode = 1'b1;
      repeat (ms * CPM) @(negedge ref_clk);
      rx_data_mode = 1'b0;
      repeat (5 * CPM) @(negedge ref_clk);
   endtask
   // Wink once the seizure is seen, or after 100 clocks at most
   task automatic wink(input int ms);
      for (int n = 0; n < 100 && !tx_data_mode; n++) @(negedge ref_clk);
      burst(ms);
   endtask
   // Receive signal present or lost
   task automatic sig(input logic v);
      @(negedge ref_clk);
      rx_signal = v;
   endtask
   // Held level for answer, seizure or clear
   task automatic lvl(input logic v);
      @(negedge ref_clk);
      rx_data_mode = v;
   endtask
endmodule
`default_nettype wire

// >>> switched56_call_supervisor_tb.sv
// Self-checking bench for the switched digital call supervisor
// Assumes sdcs_pkg, sdcs_core, sdcs_sva and sdcs_net_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module switched56_call_supervisor_tb;
   import sdcs_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sw_mode = 1'b0;
   logic rx_dm, rx_sig, tx, led_i, led_o, los, dialing, ww, wa, conn, beep, tx_q;
   sdcs_cmd_s cmd = '0;
   sdcs_event_s evt;
   logic [3:0] digits [16];
   logic [7:0] rate;
   logic [6:0] ev_v;
   logic [3:0] st;
   logic [3:0] dcnt = 4'h2;
   logic [31:0] rnd = 32'hCD9E;
   int errors = 0;
   int checks = 0;
   int pulses = 0;
   int xp = 0;
   logic [31:0] ev [7] = '{default: 32'h0};
   int xe [7] = '{default: 0};
   assign ev_v = evt;
   assign st = {beep, conn, wa, dialing};
   // 25 MHz clock
   always #20 clk = ~clk;
   // No-wink limit leaves room for a hit wink followed by a glare wink
   sdcs_core #(.CLK_HZ_P(3000), .NO_WINK_MS_P(500)) u_sdcs_core (
      .REF_CLK(clk), .RESET_N(rst_n), .SW_MODE(sw_mode), .RX_DATA_MODE(rx_dm),
      .RX_SIGNAL(rx_sig), .CMD(cmd), .DIGITS(digits), .DIGIT_COUNT(dcnt),
      .TX_DATA_MODE(tx), .LED_IDLE(led_i), .LED_ALL_ONES(led_o), .RATE_KBPS_O(rate),
      .LOS(los), .DIALING(dialing), .WAIT_WINK(ww), .WAIT_ANSWER(wa),
      .CONNECTED(conn), .BEEP(beep), .EVT(evt));
   sdcs_net_model #(.CPM(3)) u_net (
      .ref_clk(clk), .tx_data_mode(tx), .rx_data_mode(rx_dm), .rx_signal(rx_sig));
   // Event tally and dial pulse count on settled outputs
   always @(negedge clk) begin
      for (int i = 0; i < 7; i++) ev[i] += ev_v[i];
      if (dialing && tx_q && !tx) pulses++;
      tx_q <= tx;
   end
   task automatic test_done();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk_lvl(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic chk_ev(input int i);
      chk_lvl(ev[i], xe[i]);
   endtask
   // Bounded wait for a status level
   task automatic wst(input int b);
      int n;
      n = 0;
      while (st[b] !== 1'b1 && n < 20000) begin
         @(negedge clk);
         n++;
      end
      if (n == 20000) begin
         errors++;
         test_done();
      end
      repeat (2) @(negedge clk);
   endtask
   task automatic pcmd(input int b);
      @(negedge clk);
      cmd = sdcs_cmd_s'(6'h01 << b);
      @(negedge clk);
      cmd = '0;
   endtask
   // One to three random digits, every slot random; zero sends ten pulses
   task automatic set_num();
      xp = 0;
      pulses = 0;
      dcnt = 4'h1 + 4'(rnd[3:0] % 4'h3);
      for (int i = 0; i < 16; i++) begin
         rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
         digits[i] = 4'(rnd[7:0] % 8'h0A);
         if (i < int'(dcnt)) xp += (digits[i] == 4'h0) ? 10 : int'(digits[i]);
      end
   endtask
   // Main sequence
   initial begin
      digits = '{default: 4'h0};
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      sw_mode = 1'b1;
      repeat (6) @(negedge clk);
      chk_lvl(rate, 32'h38);
      chk_lvl(los, 32'h1);
      u_net.sig(1'b1);
      repeat (6) @(negedge clk);
      chk_lvl(los, 32'h0);
      $display("test signal done");
      u_net.burst(20);
      xe[3]++;
      u_net.burst(60);
      chk_ev(3);
      u_net.lvl(1'b1);
      wst(2);
      xe[0]++;
      chk_ev(0);
      u_net.lvl(1'b0);
      repeat (10) @(negedge clk);
      xe[2]++;
      chk_ev(2);
      chk_lvl(tx, 32'h0);
      $display("test receive done");
      pcmd(5);
      wst(3);
      xe[6]++;
      chk_ev(6);
      pcmd(3);
      repeat (5) @(negedge clk);
      chk_lvl({beep, tx}, 32'h0);
      pcmd(5);
      chk_lvl({ww, tx}, 32'h3);
      u_net.wink(30);
      xe[5]++;
      chk_ev(5);
      u_net.wink(400);
      xe[4]++;
      chk_ev(4);
      chk_lvl(tx, 32'h0);
      pcmd(5);
      sw_mode = 1'b0;
      repeat (5) @(negedge clk);
      chk_lvl({rate, ww, tx}, 32'h0);
      sw_mode = 1'b1;
      $display("test wink done");
      set_num();
      pcmd(5);
      chk_lvl({ww, tx}, 32'h3);
      u_net.wink(150);
      wst(0);
      wst(1);
      chk_lvl(pulses, xp);
      u_net.burst(300);
      xe[5]++;
      chk_ev(5);
      u_net.lvl(1'b1);
      wst(2);
      chk_lvl(wa, 32'h0);
      chk_lvl({led_i, led_o, conn}, 32'h3);
      pcmd(2);
      pcmd(3);
      chk_lvl(conn, 32'h1);
      pcmd(2);
      pcmd(1);
      u_net.lvl(1'b0);
      repeat (10) @(negedge clk);
      xe[1]++;
      chk_ev(1);
      chk_lvl({led_i, led_o, tx}, 32'h4);
      $display("test call done");
      set_num();
      pcmd(5);
      wst(3);
      xe[6]++;
      pcmd(4);
      wst(0);
      wst(1);
      chk_lvl(pulses, xp);
      u_net.lvl(1'b1);
      wst(2);
      pcmd(0);
      u_net.lvl(1'b0);
      repeat (10) @(negedge clk);
      xe[1]++;
      chk_ev(1);
      for (int i = 0; i < 7; i++) chk_ev(i);
      $display("test continue done");
      test_done();
   end
endmodule
bind sdcs_core sdcs_sva #(.CLK_HZ_P(CLK_HZ_P)) u_sdcs_sva (
   .REF_CLK(REF_CLK), .RESET_N(RESET_N), .SW_MODE(SW_MODE), .RX_DATA_MODE(RX_DATA_MODE),
   .RX_SIGNAL(RX_SIGNAL), .TX_DATA_MODE(TX_DATA_MODE), .LED_IDLE(LED_IDLE),
   .LED_ALL_ONES(LED_ALL_ONES), .RATE_KBPS_O(RATE_KBPS_O), .LOS(LOS), .DIALING(DIALING),
   .WAIT_WINK(WAIT_WINK), .WAIT_ANSWER(WAIT_ANSWER), .CONNECTED(CONNECTED),
   .BEEP(BEEP), .EVT(EVT));
`default_nettype wire
